// *** src/hwmsa_defs.svh ***
// register offsets, field positions and reset values of the monitor core
`ifndef HWMSA_DEFS_SVH
`define HWMSA_DEFS_SVH

`define HWMSA_REG_VALUE0   8'h20
`define HWMSA_REG_DUTY0    8'h30
`define HWMSA_REG_CONFIG   8'h40
`define HWMSA_REG_STATUS   8'h41
`define HWMSA_REG_VID      8'h43
`define HWMSA_REG_LIMIT0   8'h44
`define HWMSA_REG_SLOPE0   8'h5F
`define HWMSA_REG_FSTART0  8'h67
`define HWMSA_REG_TOFFS0   8'h70
`define HWMSA_REG_MASK     8'h74

`define HWMSA_NUM_CHAN     8
`define HWMSA_NUM_FAN      3
`define HWMSA_FIRST_TEMP   3'h5

`define HWMSA_CFG_START    0
`define HWMSA_CFG_ALERT    1
`define HWMSA_CFG_AUTO     2
`define HWMSA_CFG_XOR      3

`define HWMSA_ADDR_DEFAULT 8'h5C
`define HWMSA_ADDR_SEL_LO  8'h58
`define HWMSA_ADDR_SEL_HI  8'h5A

`define HWMSA_RST_CONFIG   8'h00
`define HWMSA_RST_MASK     8'h00
`define HWMSA_RST_LIM_LO   8'h00
`define HWMSA_RST_LIM_HI   8'hFF
`define HWMSA_RST_FSTART   8'h28
`define HWMSA_RST_SLOPE    8'h02
`define HWMSA_RST_DUTY     8'hFF

`endif

// *** src/hwmsa_pkg.sv ***
// shared types of the monitor core
package hwmsa_pkg;

  // one byte delivered by the bus protocol engine
  typedef struct packed {
    logic       valid;
    logic       first;
    logic [7:0] data;
  } hwmsa_wr_t;

  // measurement sequencer states
  typedef enum logic [2:0] {
    HWMSA_IDLE = 3'b001,
    HWMSA_CONV = 3'b010,
    HWMSA_WAIT = 3'b100
  } hwmsa_state_t;

endpackage

// *** src/hwmsa_chan.sv ***
// offset correction and limit compare of one conversion result
`timescale 1ns/10ps
`default_nettype none

module hwmsa_chan (
  // raw result and its settings
  input  wire logic [7:0] raw,
  input  wire logic [7:0] offset,
  input  wire logic       is_temp,
  input  wire logic [7:0] lim_lo,
  input  wire logic [7:0] lim_hi,
  // corrected result
  output logic      [7:0] value,
  output logic            out_of_limit
);

  logic [8:0] sum;
  logic       ovf;
  logic       above;
  logic       below;

  // signed offset add, saturated so a hot reading never wraps cold
  assign sum   = {raw[7], raw} + {offset[7], offset};
  assign ovf   = sum[8] ^ sum[7];
  assign value = !is_temp ? raw :
                 ovf ? (sum[8] ? 8'h80 : 8'h7F) : sum[7:0];

  // temperatures compare signed, voltages unsigned
  assign above = is_temp ? ($signed(value) > $signed(lim_hi))
                         : (value > lim_hi);
  assign below = is_temp ? ($signed(value) < $signed(lim_lo))
                         : (value < lim_lo);
  assign out_of_limit = above | below;

endmodule

`default_nettype wire

// *** src/hwmsa_top.sv ***
// digital core of the hardware monitor: sequencer, limits, alert, straps
//
// Contract
// - Enable strap low at power-up: the address follows the select strap.
// - Enable strap high at power-up: the address is 0x5C regardless.
// - In select mode the address is 0x58 for select low and 0x5A for high.
// - The address is frozen at the first valid bus transaction.
// - After the address freezes the enable strap pin serves fan 3 drive.
// - Once started, each channel in turn is stored in its value register.
// - Channels: four voltages, the supply, two remote and one local temp.
// - Each result is compared with its limits and failures land in status.
// - Alert mode: the shared pin goes low when any unmasked status bit sets.
// - A mask bit only hides its event from the alert, never from status.
// - The five voltage-ID pins are captured into register 0x43.
// - A write's first byte loads the pointer that selects the register.
// - Each temperature reading gets its signed offset register added.
// - In automatic mode a fan starts being driven once above its start temperature.
// - The slope register of each fan sets speed rise versus temperature.
// - In XOR test mode the fan 1 pin carries the XOR tree output.
`timescale 1ns/10ps
`default_nettype none
`include "hwmsa_defs.svh"

module hwmsa_top (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // byte port of the bus protocol engine
  input  wire logic              bus_txn_start,
  input  wire hwmsa_pkg::hwmsa_wr_t bus_wr,
  input  wire logic              bus_rd_req,
  output logic            [7:0]  bus_rd_data,
  output logic                   bus_rd_valid,
  output logic            [7:0]  slave_addr,
  output logic                   slave_addr_locked,
  // converter front end
  output logic            [2:0]  adc_chan,
  output logic                   adc_start,
  input  wire logic              adc_done,
  input  wire logic       [7:0]  adc_data,
  // processor voltage-ID pins
  input  wire logic       [4:0]  volt_id_in,
  // fan and strap pins, open drain
  output logic                   fan1_drive_or_xor_out_o,
  output logic                   fan1_drive_or_xor_out_oe,
  output logic                   fan2_drive_o,
  output logic                   fan2_drive_oe,
  input  wire logic              fan3_drive_addr_strap_en_i,
  output logic                   fan3_drive_addr_strap_en_o,
  output logic                   fan3_drive_addr_strap_en_oe,
  input  wire logic              fan4_speed_addr_strap_sel
);

  localparam int NC = `HWMSA_NUM_CHAN;
  localparam int NF = `HWMSA_NUM_FAN;

  // pin synchronisers
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic [4:0] vid_s;
  logic       strap_en_s;
  logic       strap_sel_s;

  // register file
  logic [7:0] pointer;
  logic [7:0] config_r;
  logic [7:0] status;
  logic [7:0] mask;
  logic [7:0] cpu_voltage_id_code;
  logic [7:0] value  [NC];
  logic [7:0] lim_lo [NC];
  logic [7:0] lim_hi [NC];
  logic [7:0] toffs  [NF];
  logic [7:0] fan_start_temp [NF];
  logic [7:0] fan_temp_slope [NF];
  logic [7:0] duty_man [NF];

  // sequencer
  hwmsa_pkg::hwmsa_state_t state;
  hwmsa_pkg::hwmsa_state_t next_state;
  logic [7:0] corr_value;
  logic       corr_oob;
  logic       is_temp;
  logic [1:0] temp_idx;
  logic       store;

  // fan drive
  logic [7:0] pwm_cnt;
  logic [7:0] duty [NF];
  logic [NF-1:0] fan_low;
  logic       xor_out;

  // both synchroniser stages; only the second stage is read
  always_ff @(posedge mclk) begin
    sync1 <= {fan4_speed_addr_strap_sel, fan3_drive_addr_strap_en_i,
              volt_id_in};
    sync2 <= sync1;
  end
  assign vid_s       = sync2[4:0];
  assign strap_en_s  = sync2[5];
  assign strap_sel_s = sync2[6];

  // address follows the straps until the first transaction freezes it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      slave_addr        <= `HWMSA_ADDR_DEFAULT;
      slave_addr_locked <= 1'b0;
    end else if (!slave_addr_locked) begin
      if (strap_en_s)
        slave_addr <= `HWMSA_ADDR_DEFAULT;
      else
        slave_addr <= strap_sel_s ? `HWMSA_ADDR_SEL_HI
                                  : `HWMSA_ADDR_SEL_LO;
      slave_addr_locked <= bus_txn_start;
    end
  end

  // write decode from the pointer
  logic       wr_data;
  logic       wr_lim;
  logic       wr_fan;
  logic [2:0] lim_idx;
  logic [1:0] fan_idx;
  logic [7:0] lim_off;
  logic [7:0] slope_off;
  logic [7:0] fstart_off;
  logic [7:0] toffs_off;
  logic [7:0] duty_off;
  assign wr_data    = bus_wr.valid & !bus_wr.first;
  assign lim_off    = pointer - `HWMSA_REG_LIMIT0;
  assign slope_off  = pointer - `HWMSA_REG_SLOPE0;
  assign fstart_off = pointer - `HWMSA_REG_FSTART0;
  assign toffs_off  = pointer - `HWMSA_REG_TOFFS0;
  assign duty_off   = pointer - `HWMSA_REG_DUTY0;
  assign wr_lim     = lim_off < 8'(2 * NC);
  assign lim_idx    = lim_off[3:1];
  assign wr_fan     = slope_off < 8'(NF);
  assign fan_idx    = (slope_off < 8'(NF))  ? slope_off[1:0]  :
                      (fstart_off < 8'(NF)) ? fstart_off[1:0] :
                      (toffs_off < 8'(NF))  ? toffs_off[1:0]  :
                      duty_off[1:0];

  // first byte of a write is the pointer, later bytes hit the register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pointer  <= 8'h00;
      config_r <= `HWMSA_RST_CONFIG;
      mask     <= `HWMSA_RST_MASK;
      for (int i = 0; i < NC; i++) begin
        lim_lo[i] <= `HWMSA_RST_LIM_LO;
        lim_hi[i] <= `HWMSA_RST_LIM_HI;
      end
      for (int i = 0; i < NF; i++) begin
        toffs[i]          <= 8'h00;
        fan_start_temp[i] <= `HWMSA_RST_FSTART;
        fan_temp_slope[i] <= `HWMSA_RST_SLOPE;
        duty_man[i]       <= `HWMSA_RST_DUTY;
      end
    end else if (bus_wr.valid && bus_wr.first) begin
      pointer <= bus_wr.data;
    end else if (wr_data) begin
      if (pointer == `HWMSA_REG_CONFIG)
        config_r <= bus_wr.data;
      if (pointer == `HWMSA_REG_MASK)
        mask <= bus_wr.data;
      if (wr_lim && !lim_off[0])
        lim_lo[lim_idx] <= bus_wr.data;
      if (wr_lim && lim_off[0])
        lim_hi[lim_idx] <= bus_wr.data;
      if (wr_fan)
        fan_temp_slope[fan_idx] <= bus_wr.data;
      if (fstart_off < 8'(NF))
        fan_start_temp[fan_idx] <= bus_wr.data;
      if (toffs_off < 8'(NF))
        toffs[fan_idx] <= bus_wr.data;
      if (duty_off < 8'(NF))
        duty_man[fan_idx] <= bus_wr.data;
    end
  end

  // read mux; unmapped offsets read as zero
  logic [7:0] rd_mux;
  logic [7:0] val_off;
  logic       rd_status;
  assign val_off   = pointer - `HWMSA_REG_VALUE0;
  assign rd_status = bus_rd_req && pointer == `HWMSA_REG_STATUS;
  assign rd_mux =
    (pointer == `HWMSA_REG_CONFIG) ? config_r :
    (pointer == `HWMSA_REG_STATUS) ? status :
    (pointer == `HWMSA_REG_VID)    ? cpu_voltage_id_code :
    (pointer == `HWMSA_REG_MASK)   ? mask :
    (val_off < 8'(NC))    ? value[val_off[2:0]] :
    wr_lim                ? (lim_off[0] ? lim_hi[lim_idx]
                                        : lim_lo[lim_idx]) :
    (slope_off < 8'(NF))  ? fan_temp_slope[fan_idx] :
    (fstart_off < 8'(NF)) ? fan_start_temp[fan_idx] :
    (toffs_off < 8'(NF))  ? toffs[fan_idx] :
    (duty_off < 8'(NF))   ? duty_man[fan_idx] : 8'h00;

  // read answer one cycle after the request
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_rd_data  <= 8'h00;
      bus_rd_valid <= 1'b0;
    end else begin
      bus_rd_valid <= bus_rd_req;
      if (bus_rd_req)
        bus_rd_data <= rd_mux;
    end
  end

  // vid pins tracked continuously, upper bits read zero
  always_ff @(posedge mclk) begin
    if (sys_rst)
      cpu_voltage_id_code <= 8'h00;
    else
      cpu_voltage_id_code <= {3'h0, vid_s};
  end

  // channel 0..4 voltages incl. supply, 5..7 remote1, local, remote2
  assign is_temp  = adc_chan >= `HWMSA_FIRST_TEMP;
  assign temp_idx = 2'(adc_chan - `HWMSA_FIRST_TEMP);
  assign store    = state == hwmsa_pkg::HWMSA_WAIT && adc_done;

  hwmsa_chan u_chan (
    .raw          (adc_data),
    .offset       (is_temp ? toffs[temp_idx] : 8'h00),
    .is_temp      (is_temp),
    .lim_lo       (lim_lo[adc_chan]),
    .lim_hi       (lim_hi[adc_chan]),
    .value        (corr_value),
    .out_of_limit (corr_oob)
  );

  // sequencer steps round all channels while start is set
  always_comb begin
    case (state)
      hwmsa_pkg::HWMSA_IDLE:
        next_state = config_r[`HWMSA_CFG_START] ? hwmsa_pkg::HWMSA_CONV
                                                : hwmsa_pkg::HWMSA_IDLE;
      hwmsa_pkg::HWMSA_CONV: next_state = hwmsa_pkg::HWMSA_WAIT;
      hwmsa_pkg::HWMSA_WAIT:
        next_state = !adc_done ? hwmsa_pkg::HWMSA_WAIT :
                     config_r[`HWMSA_CFG_START] ? hwmsa_pkg::HWMSA_CONV
                                                : hwmsa_pkg::HWMSA_IDLE;
      default: next_state = hwmsa_pkg::HWMSA_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state     <= hwmsa_pkg::HWMSA_IDLE;
      adc_chan  <= 3'h0;
      adc_start <= 1'b0;
      for (int i = 0; i < NC; i++)
        value[i] <= 8'h00;
    end else begin
      state     <= next_state;
      adc_start <= next_state == hwmsa_pkg::HWMSA_CONV;
      if (store) begin
        value[adc_chan] <= corr_value;
        adc_chan        <= adc_chan + 3'h1;
      end
    end
  end

  // set wins over the read clear so no event is lost
  logic [7:0] next_status;
  assign next_status = (status & ~(rd_status ? 8'hFF : 8'h00))
                     | ((store && corr_oob) ? (8'h01 << adc_chan)
                                            : 8'h00);
  always_ff @(posedge mclk) begin
    if (sys_rst)
      status <= 8'h00;
    else
      status <= next_status;
  end

  // free running pwm period counter
  always_ff @(posedge mclk) begin
    if (sys_rst)
      pwm_cnt <= 8'h00;
    else
      pwm_cnt <= pwm_cnt + 8'h01;
  end

  // per fan duty: manual, or rising from start temp by slope
  genvar f;
  generate
    for (f = 0; f < NF; f++) begin : g_fan
      logic signed [8:0]  excess;
      logic        [15:0] scaled;
      assign excess = $signed({value[5+f][7], value[5+f]})
                    - $signed({fan_start_temp[f][7], fan_start_temp[f]});
      assign scaled = {7'h00, excess} << fan_temp_slope[f][2:0];
      assign duty[f] = !config_r[`HWMSA_CFG_AUTO] ? duty_man[f] :
                       (excess <= 9'sh000) ? 8'h00 :
                       (|scaled[15:8]) ? 8'hFF : scaled[7:0];
      assign fan_low[f] = pwm_cnt >= duty[f];
    end
  endgenerate

  // test xor of every captured input
  assign xor_out = ^{vid_s, strap_en_s, strap_sel_s, adc_data, adc_done};

  // pin drivers; oe high pulls the line low
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fan1_drive_or_xor_out_oe    <= 1'b0;
      fan2_drive_oe               <= 1'b0;
      fan3_drive_addr_strap_en_oe <= 1'b0;
    end else begin
      fan1_drive_or_xor_out_oe <= config_r[`HWMSA_CFG_XOR]
                                ? !xor_out : fan_low[0];
      fan2_drive_oe <= config_r[`HWMSA_CFG_ALERT]
                     ? |(status & ~mask)
                     : fan_low[1];
      // strap pin left free until the address is frozen
      fan3_drive_addr_strap_en_oe <= slave_addr_locked & fan_low[2];
    end
  end

  // open-drain pins only ever drive low
  always_ff @(posedge mclk) begin
    fan1_drive_or_xor_out_o    <= 1'b0;
    fan2_drive_o               <= 1'b0;
    fan3_drive_addr_strap_en_o <= 1'b0;
  end

endmodule

`default_nettype wire

// *** dv/hwmsa_top_chk.sv ***
// port checks of the monitor core and their bind
`timescale 1ns/10ps
`default_nettype none
`include "hwmsa_defs.svh"

module hwmsa_top_chk (
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 sys_rst,
  // bus byte port and address
  input wire logic                 bus_txn_start,
  input wire hwmsa_pkg::hwmsa_wr_t bus_wr,
  input wire logic                 bus_rd_req,
  input wire logic [7:0]           bus_rd_data,
  input wire logic                 bus_rd_valid,
  input wire logic [7:0]           slave_addr,
  input wire logic                 slave_addr_locked,
  // converter and strap pins
  input wire logic [2:0]           adc_chan,
  input wire logic                 adc_done,
  input wire logic                 fan3_drive_addr_strap_en_i,
  input wire logic                 fan3_drive_addr_strap_en_oe,
  input wire logic                 fan4_speed_addr_strap_sel
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // straps must sit four edges to pass the two-flop sync
  sequence s_dflt;
    (fan3_drive_addr_strap_en_i && !slave_addr_locked) [*4];
  endsequence
  sequence s_sel_lo;
    (!fan3_drive_addr_strap_en_i && !fan4_speed_addr_strap_sel
     && !slave_addr_locked) [*4];
  endsequence
  sequence s_sel_hi;
    (!fan3_drive_addr_strap_en_i && fan4_speed_addr_strap_sel
     && !slave_addr_locked) [*4];
  endsequence
  sequence s_ptr_mask;
    bus_wr.valid && bus_wr.first && bus_wr.data == `HWMSA_REG_MASK;
  endsequence
  property p_addr_dflt;
    s_dflt |-> slave_addr == `HWMSA_ADDR_DEFAULT;
  endproperty
  property p_addr_lo;
    s_sel_lo |-> slave_addr == `HWMSA_ADDR_SEL_LO;
  endproperty
  property p_addr_hi;
    s_sel_hi |-> slave_addr == `HWMSA_ADDR_SEL_HI;
  endproperty
  property p_lock_set;
    bus_txn_start |=> slave_addr_locked;
  endproperty
  property p_lock_hold;
    slave_addr_locked |=> slave_addr_locked && $stable(slave_addr);
  endproperty
  property p_strap_free;
    !slave_addr_locked |-> !fan3_drive_addr_strap_en_oe;
  endproperty
  property p_rd_answer;
    bus_rd_req |=> bus_rd_valid;
  endproperty
  property p_rd_pulse;
    !bus_rd_req |=> !bus_rd_valid;
  endproperty
  // pointer, data byte, then a read at that pointer returns the byte
  property p_mask_back;
    logic [7:0] d;
    s_ptr_mask ##1 (bus_wr.valid && !bus_wr.first, d = bus_wr.data)
    ##[1:2] bus_rd_req |=> bus_rd_data == d;
  endproperty
  property p_chan_step;
    adc_done |=> adc_chan == $past(adc_chan) + 3'h1;
  endproperty

  a_addr_dflt: assert property (p_addr_dflt)
    else $error("default address wrong");
  a_addr_lo: assert property (p_addr_lo)
    else $error("select-low address wrong");
  a_addr_hi: assert property (p_addr_hi)
    else $error("select-high address wrong");
  a_lock_set: assert property (p_lock_set)
    else $error("address not locked after transaction");
  a_lock_hold: assert property (p_lock_hold)
    else $error("locked address moved");
  a_strap_free: assert property (p_strap_free)
    else $error("strap pin driven before lock");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered");
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read valid without request");
  a_mask_back: assert property (p_mask_back)
    else $error("mask readback differs");
  a_chan_step: assert property (p_chan_step)
    else $error("channel did not advance");
endmodule

bind hwmsa_top hwmsa_top_chk u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .bus_txn_start(bus_txn_start),
  .bus_wr(bus_wr), .bus_rd_req(bus_rd_req), .bus_rd_data(bus_rd_data),
  .bus_rd_valid(bus_rd_valid), .slave_addr(slave_addr),
  .slave_addr_locked(slave_addr_locked), .adc_chan(adc_chan),
  .adc_done(adc_done),
  .fan3_drive_addr_strap_en_i(fan3_drive_addr_strap_en_i),
  .fan3_drive_addr_strap_en_oe(fan3_drive_addr_strap_en_oe),
  .fan4_speed_addr_strap_sel(fan4_speed_addr_strap_sel));
`default_nettype wire

// *** dv/hwmsa_host.sv ***
// bus host model driving the byte port of the monitor core
`timescale 1ns/10ps
`default_nettype none

module hwmsa_host (
  // clock
  input  wire logic            mclk,
  // byte port toward the core
  output logic                 bus_txn_start,
  output var hwmsa_pkg::hwmsa_wr_t bus_wr,
  output logic                 bus_rd_req,
  input  wire logic [7:0]      bus_rd_data,
  input  wire logic            bus_rd_valid
);
  // idle bus from time zero
  initial begin
    bus_txn_start = 1'b0;
    bus_wr = '0;
    bus_rd_req = 1'b0;
  end

  // pointer byte then data byte; tasks enter and leave on a falling edge
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    bus_txn_start <= 1'b1;
    bus_wr <= {1'b1, 1'b1, p};
    @(negedge mclk);
    bus_txn_start <= 1'b0;
    bus_wr <= {1'b1, 1'b0, d};
    @(negedge mclk);
    bus_wr <= '0;
    @(negedge mclk);
  endtask

  // read at current pointer; the answer is taken once valid shows
  task automatic rd_cur(output logic [7:0] d);
    int n;
    bus_txn_start <= 1'b1;
    bus_rd_req <= 1'b1;
    @(negedge mclk);
    bus_txn_start <= 1'b0;
    bus_rd_req <= 1'b0;
    n = 0;
    while (bus_rd_valid !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    d = bus_rd_data;
    @(negedge mclk);
  endtask

  // pointer-only write, then a read
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    bus_txn_start <= 1'b1;
    bus_wr <= {1'b1, 1'b1, p};
    @(negedge mclk);
    bus_wr <= '0;
    rd_cur(d);
  endtask
endmodule
`default_nettype wire

// *** dv/test_hwmsa_top.sv ***
// self-checking bench of the monitor core
`timescale 1ns/10ps
`default_nettype none
`include "hwmsa_defs.svh"

module test_hwmsa_top;
  logic                 mclk;
  logic                 sys_rst;
  logic                 bus_txn_start;
  hwmsa_pkg::hwmsa_wr_t bus_wr;
  logic                 bus_rd_req;
  logic [7:0]           bus_rd_data;
  logic                 bus_rd_valid;
  logic [7:0]           slave_addr;
  logic                 slave_addr_locked;
  logic [2:0]           adc_chan;
  logic                 adc_start;
  logic                 adc_done;
  logic [7:0]           adc_data;
  logic [4:0]           volt_id_in;
  logic                 fan1_oe;
  logic                 fan2_oe;
  logic                 fan3_oe;
  logic                 strap_en;
  logic                 strap_sel;
  wire logic            fan3_pin;
  logic [1:0]           cnt;
  logic [7:0]           tbl [8];
  logic [7:0]           q;
  logic [7:0]           e;
  int                   errors;
  int                   checked;

  // open drain: pull-up gives the strap level unless the core pulls low
  assign fan3_pin = fan3_oe ? 1'b0 : strap_en;

  hwmsa_top dut (
    .mclk(mclk), .sys_rst(sys_rst), .bus_txn_start(bus_txn_start),
    .bus_wr(bus_wr), .bus_rd_req(bus_rd_req), .bus_rd_data(bus_rd_data),
    .bus_rd_valid(bus_rd_valid), .slave_addr(slave_addr),
    .slave_addr_locked(slave_addr_locked), .adc_chan(adc_chan),
    .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data),
    .volt_id_in(volt_id_in), .fan1_drive_or_xor_out_o(),
    .fan1_drive_or_xor_out_oe(fan1_oe), .fan2_drive_o(),
    .fan2_drive_oe(fan2_oe),
    .fan3_drive_addr_strap_en_i(fan3_pin), .fan3_drive_addr_strap_en_o(),
    .fan3_drive_addr_strap_en_oe(fan3_oe),
    .fan4_speed_addr_strap_sel(strap_sel));

  hwmsa_host host (
    .mclk(mclk), .bus_txn_start(bus_txn_start), .bus_wr(bus_wr),
    .bus_rd_req(bus_rd_req), .bus_rd_data(bus_rd_data),
    .bus_rd_valid(bus_rd_valid));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // converter answers three cycles after each start pulse
  always @(negedge mclk) begin
    if (adc_start)
      cnt <= 2'h3;
    else if (cnt != 2'h0)
      cnt <= cnt - 2'h1;
    adc_done <= (cnt == 2'h1);
    adc_data <= tbl[adc_chan];
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] p, input logic [7:0] exp);
    logic [7:0] got;
    host.rd(p, got);
    chk(got, exp);
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // fan 1 on-cycles over one full pwm period equal the duty
  task automatic duty_cnt(output logic [7:0] n);
    n = 8'h00;
    repeat (256) begin
      @(negedge mclk);
      if (fan1_oe === 1'b0)
        n = n + 8'h01;
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, far beyond the roughly 1100 cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    results();
  end

  initial begin
    errors = 0;
    checked = 0;
    sys_rst = 1'b1;
    volt_id_in = 5'h15;
    strap_en = 1'b1;
    strap_sel = 1'b0;
    cnt = 2'h0;
    adc_done = 1'b0;
    adc_data = 8'h00;
    tbl = '{8'h90, 8'h40, 8'h60, 8'h60, 8'h60, 8'h10, 8'h20, 8'h30};
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    // strap decode must happen before any bus traffic locks it
    wt(4);
    chk(slave_addr, `HWMSA_ADDR_DEFAULT);
    strap_sel = 1'b1;
    wt(4);
    chk(slave_addr, `HWMSA_ADDR_DEFAULT);
    strap_en = 1'b0;
    wt(4);
    chk(slave_addr, `HWMSA_ADDR_SEL_HI);
    strap_sel = 1'b0;
    wt(4);
    chk(slave_addr, `HWMSA_ADDR_SEL_LO);
    rchk(`HWMSA_REG_VID, 8'h15);
    strap_sel = 1'b1;
    strap_en = 1'b1;
    wt(4);
    chk(slave_addr, `HWMSA_ADDR_SEL_LO);
    chk({7'h00, slave_addr_locked}, 8'h01);
    $display("test straps done");
    // reset values, read-only and unmapped places
    rchk(`HWMSA_REG_CONFIG, `HWMSA_RST_CONFIG);
    rchk(`HWMSA_REG_MASK, `HWMSA_RST_MASK);
    rchk(`HWMSA_REG_LIMIT0 + 8'h01, `HWMSA_RST_LIM_HI);
    host.wr(`HWMSA_REG_VID, 8'hAA);
    rchk(`HWMSA_REG_VID, 8'h15);
    rchk(8'hF0, 8'h00);
    host.wr(`HWMSA_REG_MASK, 8'h5A);
    host.rd_cur(q);
    chk(q, 8'h5A);
    $display("test registers done");
    // one high and one low failure, temp offset, alert then masked
    host.wr(`HWMSA_REG_MASK, 8'h00);
    host.wr(`HWMSA_REG_LIMIT0 + 8'h01, 8'h80);
    host.wr(`HWMSA_REG_LIMIT0 + 8'h02, 8'h50);
    host.wr(`HWMSA_REG_TOFFS0, 8'hFE);
    host.wr(`HWMSA_REG_CONFIG, 8'h03);
    wt(150);
    chk({7'h00, fan2_oe}, 8'h01);
    host.wr(`HWMSA_REG_MASK, 8'hFF);
    wt(3);
    chk({7'h00, fan2_oe}, 8'h00);
    host.wr(`HWMSA_REG_CONFIG, 8'h02);
    wt(30);
    host.rd(`HWMSA_REG_STATUS, q);
    chk(q & 8'h1F, 8'h03);
    rchk(`HWMSA_REG_STATUS, 8'h00);
    for (int i = 0; i < 8; i++) begin
      e = tbl[i];
      if (i == 5)
        e = tbl[5] - 8'h02;
      rchk(`HWMSA_REG_VALUE0 + 8'(i), e);
    end
    $display("test measurement done");
    // automatic fan: duty rises from the start temp by the slope shift
    host.wr(`HWMSA_REG_FSTART0, 8'h0D);
    host.wr(`HWMSA_REG_CONFIG, 8'h04);
    wt(2);
    duty_cnt(q);
    chk(q, 8'h04);
    host.wr(`HWMSA_REG_FSTART0, 8'h0E);
    wt(2);
    duty_cnt(q);
    chk(q, 8'h00);
    host.wr(`HWMSA_REG_FSTART0, 8'h00);
    host.wr(`HWMSA_REG_SLOPE0, 8'h03);
    wt(2);
    duty_cnt(q);
    chk(q, 8'h70);
    $display("test fan control done");
    // xor mode; fan 3 held low so the strap line stays still
    host.wr(`HWMSA_REG_DUTY0 + 8'h02, 8'h00);
    host.wr(`HWMSA_REG_CONFIG, 8'h08);
    wt(4);
    chk({7'h00, fan3_oe}, 8'h01);
    q = {7'h00, fan1_oe};
    volt_id_in = 5'h14;
    wt(4);
    chk({7'h00, fan1_oe}, q ^ 8'h01);
    rchk(`HWMSA_REG_VID, 8'h14);
    $display("test xor mode done");
    // a second reset unlocks the address again
    sys_rst = 1'b1;
    wt(2);
    sys_rst = 1'b0;
    wt(4);
    chk(slave_addr, `HWMSA_ADDR_DEFAULT);
    chk({7'h00, slave_addr_locked}, 8'h00);
    rchk(`HWMSA_REG_CONFIG, `HWMSA_RST_CONFIG);
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire
